// ---- src/dpll_loop.sv ----
// Digital PLL loop: frequency detector, PI controller, table and sigma-delta stages
// How it works
// - Count output clock per reference window
// - 16-bit counter, increments taken modulo wrap
// - 15Q16 terms, 64-bit products and sums
// - Output sums scaled error, integral, double integral
// - Both accumulators clipped to wind-up limit
// - Table mode limit is twice max deviation
// - Table mode output indexes monotonic settings
// - Each table entry is two bytes
// - Sigma-delta writes nine levels at 1 MHz
// - Sigma-delta modulator is third order
// - Sigma-delta mode low-pass filters the error
// - Optional sample deferral to bit-clock edge, scaled
// - Fixed mode: 24 MHz crystal, six outputs
`timescale 1ns/1ps
`include "dpll_params.svh"
module dpll_loop import dpll_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire mode_t mode,
  input wire logic defer_en,
  input wire logic ref_tick,
  input wire logic bclk_edge,
  input wire logic [`CNT_W-1:0] out_count,
  input wire logic [`CNT_W-1:0] nominal_incr,
  input wire logic [31:0] defer_rate_q16,
  input wire logic signed [31:0] kp,
  input wire logic signed [31:0] ki,
  input wire logic signed [31:0] kii,
  input wire logic signed [31:0] sdm_range,
  input wire logic [`LUT_AW-1:0] lut_center,
  input wire logic [`FRAC_W-1:0] sdm_base,
  input wire logic [2:0] fixed_sel,
  input wire logic lut_wr_en,
  input wire logic [`LUT_AW-1:0] lut_wr_addr,
  input wire logic [`FRAC_W-1:0] lut_wr_data,
  output logic frac_wr_ff,
  output logic [`FRAC_W-1:0] frac_ff,
  output logic signed [`CNT_W:0] freq_err_ff,
  output logic [`LUT_AW-1:0] lut_index_ff
);
  localparam int SDM_TICKS = `SDM_TICKS;
  loop_st_t state_ff, nxt_state;
  logic [`CNT_W-1:0] sample_ff, prev_ff, lat_ff;
  logic primed_ff;
  logic signed [63:0] filt_ff, integ_ff, dint_ff, ctrl_ff;
  logic signed [31:0] sdm_x_ff, e1_ff, e2_ff, e3_ff;
  logic [7:0] tick_cnt_ff;
  logic fixed_done_ff;
  logic [2:0] fixed_last_ff;

  lut_if lut_bus ();
  lut_mem u_mem (.clk(clk), .bus(lut_bus));
  assign lut_bus.wr_en = lut_wr_en;
  assign lut_bus.wr_addr = lut_wr_addr;
  assign lut_bus.wr_data = lut_wr_data;

  function automatic logic signed [63:0] clip(input logic signed [63:0] v,
                                              input logic signed [63:0] lim);
    clip = (v > lim) ? lim : ((v < -lim) ? -lim : v);
  endfunction

  // latency since reference edge, scaled to output-clock cycles
  wire [47:0] lat_prod = {32'h0000_0000, lat_ff} * {16'h0000, defer_rate_q16};
  wire [`CNT_W-1:0] deferred_cnt = out_count - lat_prod[31:16];
  wire [`CNT_W-1:0] incr = sample_ff - prev_ff;
  wire signed [`CNT_W:0] err_now = $signed({1'b0, nominal_incr}) - $signed({1'b0, incr});
  // error promoted to 15Q16 in 64 bits
  wire signed [63:0] e_q = {{31{freq_err_ff[`CNT_W]}}, freq_err_ff, 16'h0000};
  wire signed [63:0] nxt_filt = filt_ff + ((e_q - filt_ff) >>> `LPF_SHIFT);
  wire signed [63:0] e_pi = (mode == MODE_SDM) ? filt_ff : e_q;
  // table limit of twice the half-table deviation
  wire signed [63:0] lut_lim = 64'(`LUT_DEPTH) <<< `Q_FRAC;
  wire signed [63:0] lim = (mode == MODE_LUT) ? lut_lim : 64'(sdm_range);
  wire signed [63:0] nxt_integ = clip(integ_ff + e_pi, lim);
  wire signed [63:0] nxt_dint = clip(dint_ff + nxt_integ, lim);
  wire signed [63:0] pi_sum = 64'(kp) * e_pi + 64'(ki) * integ_ff + 64'(kii) * dint_ff;
  // index around table centre, held inside the table
  wire signed [63:0] idx_raw = $signed({55'h0, lut_center}) + (ctrl_ff >>> `Q_FRAC);
  wire [`LUT_AW-1:0] idx_clamp = (idx_raw < 0) ? '0 :
    (idx_raw > 64'(`LUT_DEPTH - 1)) ? `LUT_AW'(`LUT_DEPTH - 1) : idx_raw[`LUT_AW-1:0];
  // Read at the index being chosen, so the word is ready in the write state
  assign lut_bus.rd_addr = idx_clamp;
  wire signed [63:0] sdm_lim = 64'(`SDM_QMAX) <<< `Q_FRAC;
  wire signed [63:0] sdm_x_clip = clip(ctrl_ff, sdm_lim);

  // error feedback with noise transfer (1 - z^-1)^3
  wire signed [31:0] sdm_v = sdm_x_ff + 3 * e1_ff - 3 * e2_ff + e3_ff;
  wire signed [31:0] q_raw = (sdm_v + 32'sh0000_8000) >>> `Q_FRAC;
  // quantiser limited to nine levels, -4 to +4
  wire signed [31:0] q_lvl = (q_raw > `SDM_QMAX) ? `SDM_QMAX :
                             ((q_raw < -`SDM_QMAX) ? -`SDM_QMAX : q_raw);
  wire signed [31:0] sdm_e = sdm_v - (q_lvl <<< `Q_FRAC);
  wire [`FRAC_W-1:0] sdm_frac = sdm_base + 16'(q_lvl * $signed({1'b0, `SDM_STEP}));
  wire sdm_tick = (tick_cnt_ff == 8'(SDM_TICKS - 1));
  wire [`FRAC_W-1:0] sdm_offs = frac_ff - sdm_base;

  // fixed settings for a 24 MHz crystal
  wire [`FRAC_W-1:0] fixed_word = (fixed_sel == 3'h0) ? `FIXED_CFG_0 :
                                  (fixed_sel == 3'h1) ? `FIXED_CFG_1 :
                                  (fixed_sel == 3'h2) ? `FIXED_CFG_2 :
                                  (fixed_sel == 3'h3) ? `FIXED_CFG_3 :
                                  (fixed_sel == 3'h4) ? `FIXED_CFG_4 : `FIXED_CFG_5;
  wire fixed_go = (mode == MODE_FIXED) && (!fixed_done_ff || fixed_sel != fixed_last_ff);
  wire loop_on = (mode == MODE_LUT) || (mode == MODE_SDM);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (ref_tick && loop_on) begin
          nxt_state = defer_en ? ST_DEFER : ST_ERR;
        end
      end
      ST_DEFER: begin
        if (bclk_edge) begin
          nxt_state = ST_ERR;
        end
      end
      ST_ERR: nxt_state = primed_ff ? ST_INTEG : ST_IDLE;
      ST_INTEG: nxt_state = ST_CTRL;
      ST_CTRL: nxt_state = (mode == MODE_LUT) ? ST_FETCH : ST_IDLE;
      ST_FETCH: nxt_state = ST_WRITE;
      ST_WRITE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst || !loop_on) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // sample the output-clock count at the window edge
  always_ff @(posedge clk) begin
    if (srst) begin
      sample_ff <= '0;
      lat_ff <= '0;
    end else if (state_ff == ST_IDLE && ref_tick && loop_on) begin
      sample_ff <= out_count;
      // Capture edge already counts as one cycle of latency
      lat_ff <= 16'h0001;
    end else if (state_ff == ST_DEFER) begin
      lat_ff <= lat_ff + 16'h0001;
      // deferred sample, scaled back to the window edge
      if (bclk_edge) begin
        sample_ff <= deferred_cnt;
      end
    end
  end

  // First window only seeds the previous sample
  always_ff @(posedge clk) begin
    if (srst || !loop_on) begin
      prev_ff <= '0;
      primed_ff <= 1'b0;
      freq_err_ff <= '0;
      filt_ff <= '0;
    end else if (state_ff == ST_ERR) begin
      prev_ff <= sample_ff;
      primed_ff <= 1'b1;
      if (primed_ff) begin
        freq_err_ff <= err_now;
      end
    end else if (state_ff == ST_INTEG) begin
      filt_ff <= nxt_filt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !loop_on) begin
      integ_ff <= '0;
      dint_ff <= '0;
      ctrl_ff <= '0;
      sdm_x_ff <= '0;
    end else if (state_ff == ST_INTEG) begin
      integ_ff <= nxt_integ;
      dint_ff <= nxt_dint;
    end else if (state_ff == ST_CTRL) begin
      ctrl_ff <= pi_sum >>> `Q_FRAC;
    end else if (state_ff == ST_FETCH || mode == MODE_SDM) begin
      sdm_x_ff <= 32'(sdm_x_clip);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lut_index_ff <= `LUT_AW'(`LUT_DEPTH / 2);
    end else if (state_ff == ST_FETCH) begin
      lut_index_ff <= idx_clamp;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || mode != MODE_SDM) begin
      tick_cnt_ff <= '0;
      e1_ff <= '0;
      e2_ff <= '0;
      e3_ff <= '0;
    end else begin
      tick_cnt_ff <= sdm_tick ? 8'h00 : tick_cnt_ff + 8'h01;
      if (sdm_tick) begin
        e1_ff <= sdm_e;
        e2_ff <= e1_ff;
        e3_ff <= e2_ff;
      end
    end
  end

  // Fixed word written on entering fixed mode and again whenever the choice changes
  always_ff @(posedge clk) begin
    if (srst || mode != MODE_FIXED) begin
      fixed_done_ff <= 1'b0;
      fixed_last_ff <= '0;
    end else if (fixed_go) begin
      fixed_done_ff <= 1'b1;
      fixed_last_ff <= fixed_sel;
    end
  end

  // Table read lags the index by one cycle, hence the extra write state
  always_ff @(posedge clk) begin
    if (srst) begin
      frac_wr_ff <= 1'b0;
      frac_ff <= '0;
    end else begin
      frac_wr_ff <= fixed_go || (mode == MODE_SDM && sdm_tick) || state_ff == ST_WRITE;
      if (fixed_go) begin
        frac_ff <= fixed_word;
      end else if (mode == MODE_SDM && sdm_tick) begin
        frac_ff <= sdm_frac;
      end else if (state_ff == ST_WRITE) begin
        frac_ff <= lut_bus.rd_data;
      end
    end
  end

  chk_err_sign: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ST_ERR && primed_ff && incr < nominal_incr) |=> freq_err_ff > 0)
    else $error("slow output did not give positive error");
  chk_wrap_incr: assert property (@(posedge clk) disable iff (srst)
    (state_ff == ST_ERR && primed_ff) |=>
    freq_err_ff == $signed({1'b0, nominal_incr}) - $signed({1'b0, 16'($past(sample_ff) -
    $past(prev_ff))}))
    else $error("count increment mishandled");
  chk_integ_clip: assert property (@(posedge clk) disable iff (srst)
    $past(state_ff) == ST_INTEG && $stable(mode) |-> integ_ff <= lim && integ_ff >= -lim)
    else $error("integral beyond wind-up limit");
  chk_dint_clip: assert property (@(posedge clk) disable iff (srst)
    $past(state_ff) == ST_INTEG && $stable(mode) |-> dint_ff <= lim && dint_ff >= -lim)
    else $error("double integral beyond wind-up limit");
  chk_lut_write: assert property (@(posedge clk) disable iff (srst)
    state_ff == ST_FETCH && mode == MODE_LUT && !fixed_go ##1 state_ff == ST_WRITE |=>
    frac_wr_ff && frac_ff == $past(lut_bus.rd_data))
    else $error("table setting not written");
  chk_sdm_rate: assert property (@(posedge clk) disable iff (srst)
    mode == MODE_SDM && sdm_tick |=> frac_wr_ff ##1 !frac_wr_ff [*8])
    else $error("sigma-delta update rate wrong");
  chk_sdm_levels: assert property (@(posedge clk) disable iff (srst)
    mode == MODE_SDM && sdm_tick |=> sdm_offs[7:0] == 8'h00 &&
    $signed(sdm_offs) <= 16'sh0400 && $signed(sdm_offs) >= -16'sh0400)
    else $error("sigma-delta level out of range");
  chk_defer_wait: assert property (@(posedge clk) disable iff (srst)
    state_ff == ST_DEFER && !bclk_edge && loop_on |=> state_ff == ST_DEFER)
    else $error("deferred sample taken early");
  chk_fixed_write: assert property (@(posedge clk) disable iff (srst)
    fixed_go && fixed_sel <= `FIXED_SEL_MAX |=> frac_wr_ff && frac_ff == $past(fixed_word))
    else $error("fixed setting not written");
  cov_lut_write: cover property (@(posedge clk) state_ff == ST_WRITE && mode == MODE_LUT);
  cov_sdm_write: cover property (@(posedge clk) mode == MODE_SDM && sdm_tick && q_lvl != 0);
  cov_defer_path: cover property (@(posedge clk) state_ff == ST_DEFER ##1 state_ff == ST_ERR);
endmodule // dpll_loop

// ---- src/dpll_params.svh ----
// Constants for the digital PLL loop controller
`ifndef DPLL_PARAMS_SVH
`define DPLL_PARAMS_SVH
`define CLK_HZ 100000000
`define SDM_RATE_HZ 1000000
`define SDM_TICKS (`CLK_HZ / `SDM_RATE_HZ)
`define CNT_W 16
`define FRAC_W 16
`define Q_FRAC 16
`define LUT_AW 9
`define LUT_DEPTH 512
`define SDM_QMAX 4
`define SDM_STEP 16'h0100
`define LPF_SHIFT 3
`define XTAL_HZ 24000000
`define FIXED_OUT_HZ_0 11289600
`define FIXED_OUT_HZ_1 12288000
`define FIXED_OUT_HZ_2 22579200
`define FIXED_OUT_HZ_3 24576000
`define FIXED_OUT_HZ_4 45158400
`define FIXED_OUT_HZ_5 49152000
`define FIXED_CFG_0 16'h1000
`define FIXED_CFG_1 16'h1100
`define FIXED_CFG_2 16'h2000
`define FIXED_CFG_3 16'h2100
`define FIXED_CFG_4 16'h3000
`define FIXED_CFG_5 16'h3100
`define FIXED_SEL_MAX 3'h5
`endif

// ---- src/dpll_pkg.sv ----
// Types shared by the digital PLL loop controller
package dpll_pkg;
  typedef enum logic [1:0] {MODE_LUT, MODE_SDM, MODE_FIXED, MODE_OFF} mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_DEFER, ST_ERR, ST_INTEG, ST_CTRL, ST_FETCH,
                            ST_WRITE} loop_st_t;
endpackage

// ---- src/lut_if.sv ----
// Carrier between the loop controller and its setting table
`timescale 1ns/1ps
`include "dpll_params.svh"
interface lut_if;
  logic wr_en;
  logic [`LUT_AW-1:0] wr_addr;
  logic [`FRAC_W-1:0] wr_data;
  logic [`LUT_AW-1:0] rd_addr;
  logic [`FRAC_W-1:0] rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface // lut_if

// ---- src/lut_mem.sv ----
// Table of fractional settings, one 16-bit word per entry, registered read
`timescale 1ns/1ps
`include "dpll_params.svh"
module lut_mem (
  input wire logic clk,
  lut_if.mem bus
);
  logic [`FRAC_W-1:0] mem_ff [`LUT_DEPTH];
  logic [`FRAC_W-1:0] rd_ff;

  always_ff @(posedge clk) begin
    if (bus.wr_en) begin
      mem_ff[bus.wr_addr] <= bus.wr_data;
    end
    rd_ff <= mem_ff[bus.rd_addr];
  end

  assign bus.rd_data = rd_ff;
endmodule // lut_mem

// ---- tb/ref_source.sv ----
// Reference window source and free-running output-clock counter
`timescale 1ns/1ps
module ref_source (
  input wire logic clk,
  input wire logic [15:0] step,
  input wire logic [15:0] win,
  output logic ref_tick,
  output logic [15:0] out_count,
  output logic bclk_edge
);
  logic [15:0] cnt_ff = 16'h0000;
  logic [15:0] win_cnt_ff = 16'h0000;
  logic [15:0] step_ff = 16'h0000;
  logic [1:0] bclk_ff = 2'h0;
  // New rate applies only from a window boundary; the boundary edge itself still adds the old step
  always @(posedge clk) begin
    cnt_ff <= cnt_ff + step_ff;
    win_cnt_ff <= ref_tick ? 16'h0000 : win_cnt_ff + 16'h0001;
    bclk_ff <= bclk_ff + 2'h1;
    if (ref_tick) begin
      step_ff <= step;
    end
  end
  // Counter wraps modulo 2^16 like a real port counter
  assign out_count = cnt_ff;
  assign ref_tick = (win_cnt_ff == win - 16'h0001);
  assign bclk_edge = (bclk_ff == 2'h3);
endmodule // ref_source

// ---- tb/tb_digital_pll_loop_controller.sv ----
// Self-checking bench for the digital PLL loop controller
`timescale 1ns/1ps
`include "dpll_params.svh"
module tb_digital_pll_loop_controller import dpll_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  mode_t mode = MODE_OFF;
  logic ref_tick, bclk_edge, frac_wr_ff;
  logic [15:0] out_count, frac_ff, nominal_incr = 16'h03E8, step = 16'h0014;
  logic [15:0] sdm_base = 16'h8000, lut_wr_data = 16'h0000;
  logic signed [31:0] kp = 32'sh0, ki = 32'sh0, kii = 32'sh0, sdm_range = 32'sh00040000;
  logic defer_en = 1'b0;
  logic [31:0] defer_rate_q16 = 32'h00000000;
  logic [8:0] lut_center = 9'h100, lut_wr_addr = 9'h000, lut_index_ff;
  logic [2:0] fixed_sel = 3'h0;
  logic lut_wr_en = 1'b0;
  logic signed [16:0] freq_err_ff;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  dpll_loop uut (.clk(clk), .srst(srst), .mode(mode), .defer_en(defer_en), .ref_tick(ref_tick),
    .bclk_edge(bclk_edge), .out_count(out_count), .nominal_incr(nominal_incr),
    .defer_rate_q16(defer_rate_q16), .kp(kp), .ki(ki), .kii(kii), .sdm_range(sdm_range),
    .lut_center(lut_center), .sdm_base(sdm_base), .fixed_sel(fixed_sel),
    .lut_wr_en(lut_wr_en), .lut_wr_addr(lut_wr_addr), .lut_wr_data(lut_wr_data),
    .frac_wr_ff(frac_wr_ff), .frac_ff(frac_ff), .freq_err_ff(freq_err_ff),
    .lut_index_ff(lut_index_ff));
  ref_source far_end (.clk(clk), .step(step), .win(16'h0032), .ref_tick(ref_tick),
    .out_count(out_count), .bclk_edge(bclk_edge));
  task automatic tally_and_finish();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Whole run needs about 4000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
    checks++;
    if (exp !== got) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_wr();
    int n;
    n = 0;
    @(negedge clk);
    while (frac_wr_ff !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("frac_wr_ff", 17'h00001, 17'(frac_wr_ff));
  endtask
  function automatic logic [15:0] lut_word(input logic [8:0] i);
    return {4'h0, i, 3'h0} + 16'h0400;
  endfunction
  task automatic t_reset();
    @(negedge clk);
    check("frac_wr_ff", 17'h00000, 17'(frac_wr_ff));
    check("frac_ff", 17'h00000, 17'(frac_ff));
    check("freq_err_ff", 17'h00000, 17'(freq_err_ff));
    check("lut_index_ff", 17'h00100, 17'(lut_index_ff));
  endtask
  // Rising table so a higher index means a higher frequency
  task automatic t_load();
    for (int i = 0; i < 512; i++) begin
      lut_wr_en = 1'b1;
      lut_wr_addr = 9'(i);
      lut_wr_data = lut_word(9'(i));
      @(negedge clk);
    end
    lut_wr_en = 1'b0;
  endtask
  task automatic t_fixed();
    logic [15:0] cfg [0:6];
    cfg = '{`FIXED_CFG_0, `FIXED_CFG_1, `FIXED_CFG_2, `FIXED_CFG_3, `FIXED_CFG_4,
            `FIXED_CFG_5, `FIXED_CFG_5};
    mode = MODE_FIXED;
    for (int s = 0; s < 7; s++) begin
      fixed_sel = 3'(s);
      wait_wr();
      check("fixed frac_ff", 17'(cfg[s]), 17'(frac_ff));
    end
  endtask
  // Fresh loop state each call; early windows may straddle a rate change
  task automatic t_track(input logic signed [31:0] p, input logic signed [31:0] i,
                         input logic [15:0] st, input logic [15:0] nom, input int n,
                         input logic [8:0] idx, input logic [16:0] err);
    mode = MODE_OFF;
    @(negedge clk);
    kp = p;
    ki = i;
    step = st;
    nominal_incr = nom;
    mode = MODE_LUT;
    repeat (n) wait_wr();
    check("freq_err_ff", err, 17'(freq_err_ff));
    check("lut_index_ff", 17'(idx), 17'(lut_index_ff));
    check("lut frac_ff", 17'(lut_word(idx)), 17'(frac_ff));
  endtask
  // Large error drives the modulator input into its clip at four steps
  task automatic t_sdm();
    int t0;
    logic [15:0] d;
    logic lvl_ok;
    mode = MODE_OFF;
    @(negedge clk);
    kp = 32'sh00010000;
    ki = 32'sh0;
    nominal_incr = 16'h044C;
    mode = MODE_SDM;
    wait_wr();
    for (int k = 0; k < 6; k++) begin
      t0 = cycles;
      wait_wr();
      check("sdm period", 17'h00064, 17'(cycles - t0));
      d = frac_ff - sdm_base;
      lvl_ok = d[7:0] == 8'h00 && $signed(d) >= -16'sh0400 && $signed(d) <= 16'sh0400;
      check("sdm level", 17'h00001, 17'(lvl_ok));
    end
    // Input clipped to exactly four steps leaves no quantiser error
    check("sdm top level", 17'h00400, 17'(d));
  endtask
  initial begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_load();
    t_fixed();
    t_track(32'sh00010000, 32'sh0, 16'h0014, 16'h03F2, 4, 9'h10A, 17'h0000A);
    t_track(32'sh00010000, 32'sh0, 16'h0015, 16'h03F2, 4, 9'h0D8, 17'h1FFD8);
    t_track(32'sh0, 32'sh00004000, 16'h0014, 16'h041A, 25, 9'h180, 17'h00032);
    // Deferred sampling, scaled at 20 output counts per clock
    defer_en = 1'b1;
    defer_rate_q16 = 32'h00140000;
    t_track(32'sh00010000, 32'sh0, 16'h0014, 16'h03DE, 4, 9'h0F6, 17'h1FFF6);
    defer_en = 1'b0;
    // Double integral alone moves the index, up to its clip
    kii = 32'sh00001000;
    t_track(32'sh0, 32'sh0, 16'h0014, 16'h03F2, 12, 9'h120, 17'h0000A);
    kii = 32'sh0;
    t_sdm();
    tally_and_finish();
  end
endmodule // tb_digital_pll_loop_controller
